// *** hdl/mmsc_pkg.sv ***
/*
  mmsc_pkg: constants and types for the module management, status and control block.
  assumes a 100 MHz core clock; all pins are sampled through two-stage synchronisers.
*/
package mmsc_pkg;

  localparam int CLK_HZ = 100_000_000;
  localparam int LANES  = 4;

  // times as specified, counts derived from the clock rate
  localparam int T_INIT_MS        = 2000;
  localparam int INIT_CYCLES      = T_INIT_MS * (CLK_HZ / 1000);
  localparam int T_RESET_MIN_US   = 2;
  localparam int RESET_MIN_CYCLES = T_RESET_MIN_US * (CLK_HZ / 1_000_000);
  localparam logic [7:0] RESET_MIN_CNT = 8'(RESET_MIN_CYCLES);

  // two-wire bus device address (0xa0 as an 8-bit write address)
  localparam logic [6:0] DEV_ADDR = 7'h50;

  // byte map
  localparam logic [7:0] ADDR_IDENT      = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h02;
  localparam logic [7:0] ADDR_FLAG_LOS   = 8'h03;
  localparam logic [7:0] ADDR_FLAG_FAULT = 8'h04;
  localparam logic [7:0] ADDR_CTRL_POWER = 8'h5d;
  localparam logic [7:0] ADDR_MASK_LOS   = 8'h64;
  localparam logic [7:0] ADDR_MASK_FAULT = 8'h65;

  // field positions
  localparam int STATUS_DNR_BIT   = 0;
  localparam int CTRL_OVR_BIT     = 0;

  // values after reset, and the bit count of a full byte
  localparam logic [7:0] MASK_RST  = 8'h00;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [3:0] CNT_BYTE  = 4'h8;

  typedef enum logic [2:0] {
    MS_RESET = 3'h1,
    MS_INIT  = 3'h2,
    MS_READY = 3'h4
  } mmsc_mstate_type;

  typedef enum logic [6:0] {
    SER_IDLE  = 7'h01,
    SER_ADDR  = 7'h02,
    SER_AACK  = 7'h04,
    SER_WDATA = 7'h08,
    SER_WACK  = 7'h10,
    SER_RDATA = 7'h20,
    SER_RACK  = 7'h40
  } mmsc_serial_type;

endpackage

// *** hdl/mmsc_flag_if.sv ***
/*
  mmsc_flag_if: carries flag sources, clears, masks and the summed attention between
  the control top and the flag bank. assumes both ends share one clock.
*/
`timescale 1ns/100ps
interface mmsc_flag_if #(parameter int N = 8);
  logic [N-1:0] cond;
  logic [N-1:0] clear;
  logic [N-1:0] mask;
  logic [N-1:0] flags;
  logic         wipe;
  logic         ready_evt;
  logic         ready_clr;
  logic         ready_pend;
  logic         attention;

  modport ctl (output cond, clear, mask, wipe, ready_evt, ready_clr,
               input  flags, ready_pend, attention);
  modport bank (input  cond, clear, mask, wipe, ready_evt, ready_clr,
                output flags, ready_pend, attention);
endinterface

// *** hdl/mmsc_flag_bank.sv ***
/*
  mmsc_flag_bank: latched event flags with clear-on-read and masking, summed into one
  attention level. assumes synchronised, same-clock condition inputs.
*/
`timescale 1ns/100ps
module mmsc_flag_bank #(
  parameter int N = 8
) (
  input  wire logic  clk_i,
  input  wire logic  reset_i,
  mmsc_flag_if.bank  fi
);

  logic [N-1:0] cond_q;
  logic [N-1:0] flags_q;
  logic         pend_q;
  logic [N-1:0] rise_w;

  assign rise_w = fi.cond & ~cond_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cond_q <= '0;
    end else begin
      cond_q <= fi.cond;
    end
  end

  // a new edge in the clearing cycle survives: set wins
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      flags_q <= '0;
    end else if (fi.wipe) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~fi.clear) | rise_w;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pend_q <= 1'b0;
    end else if (fi.wipe) begin
      pend_q <= 1'b0;
    end else if (fi.ready_evt) begin
      pend_q <= 1'b1;
    end else if (fi.ready_clr) begin
      pend_q <= 1'b0;
    end
  end

  assign fi.flags      = flags_q;
  assign fi.ready_pend = pend_q;
  assign fi.attention  = (|(flags_q & ~fi.mask)) | pend_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  flag_set_a: assert property ((rise_w != '0 && !fi.wipe) |=> (flags_q & $past(rise_w)) == $past(rise_w))
    else $error("flag not set after its condition rose");
  flag_clear_a: assert property ((fi.clear != '0 && (fi.clear & rise_w) == '0) |=> (flags_q & $past(fi.clear)) == '0)
    else $error("flag survived its clear-on-read");
  set_wins_a: assert property ((fi.clear & rise_w) != '0 && !fi.wipe |=> (flags_q & $past(fi.clear & rise_w)) != '0)
    else $error("event lost in the clearing cycle");

endmodule

// *** hdl/mmsc_top.sv ***
/*
  mmsc_top: management control and status logic of a four-lane pluggable module:
  reset qualification, initialisation timing, two-wire serial slave with select gating,
  clear-on-read flags with masks, attention output and low-power control.
  assumes asynchronous pins, sampled by a 100 MHz clock well above the serial clock rate.
*/
`timescale 1ns/100ps
// How it works
// - after power-on or reset release, ready state reached within 2000 ms
// - reset pin low longer than 2 us is a reset request
// - serial bus answered within 2000 ms of power-on
// - data-not-ready clears and attention asserts within 2000 ms of power-on
// - ready means attention asserted because data-not-ready cleared
// - after reset pin rises, ready within 2000 ms
// - low-power pin high drops power level within 100 us
// - attention driven low within 200 ms of any triggering condition
// - reading a flag clears it; attention released within 500 us
// - loss-of-signal sets its flag and attention within 100 ms
// - other conditions set their flag and attention within 200 ms
// - setting a mask bit inhibits its source within 100 ms
// - clearing a mask bit restores its source within 100 ms
// - select asserted: serial responses start within 100 us
// - select deasserted: serial responses stop within 100 us
// - power override set: lower power level within 100 ms
// - power override cleared: fully functional within 300 ms
// - write-started timings run from the end of that write
module mmsc_top #(
  parameter int         INIT_CYCLES = mmsc_pkg::INIT_CYCLES,
  parameter logic [7:0] IDENT_CODE  = 8'h5a  // arbitrary identifier value
) (
  input  wire logic                       clk_i,
  input  wire logic                       reset_i,
  input  wire logic                       module_reset_n_i,
  input  wire logic                       module_select_n_i,
  input  wire logic                       low_power_request_i,
  input  wire logic                       scl_i,
  input  wire logic                       sda_i,
  input  wire logic [mmsc_pkg::LANES-1:0] rx_los_i,
  input  wire logic [mmsc_pkg::LANES-1:0] tx_fault_i,
  output logic                            sda_o,
  output logic                            sda_oe_o,
  output logic                            attention_out_n_o,
  output logic                            presence_out_n_o,
  output logic                            low_power_o,
  output logic                            data_not_ready_o
);

  localparam int NSYNC = 5 + 2 * mmsc_pkg::LANES;
  // reset to the pins' idle levels, so that no false edge or low-power pulse follows reset
  localparam logic [NSYNC-1:0] SYNC_RST = {5'h1e, {(2 * mmsc_pkg::LANES){1'b0}}};

  logic [NSYNC-1:0] sync_m_q;
  logic [NSYNC-1:0] sync_s_q;
  logic             rst_n_s;
  logic             sel_n_s;
  logic             lp_s;
  logic             scl_s;
  logic             sda_s;
  logic             scl_prev_q;
  logic             sda_prev_q;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_w;
  logic             stop_w;

  mmsc_pkg::mmsc_mstate_type ms_q;
  logic [7:0]       rst_cnt_q;
  logic [31:0]      init_cnt_q;
  logic             ready_evt_q;
  logic             dnr_q;
  logic             soft_rst_w;

  mmsc_pkg::mmsc_serial_type ser_q;
  logic [3:0]       cnt_q;
  logic [7:0]       shift_q;
  logic [7:0]       tx_q;
  logic [7:0]       ptr_q;
  logic             rw_q;
  logic             first_q;
  logic             drive_q;
  logic             live_w;
  logic             wr_w;
  logic             ld_w;
  logic [7:0]       rd_byte;

  logic [7:0]       mask_los_q;
  logic [7:0]       mask_fault_q;
  logic [7:0]       ctrl_q;
  logic             lp_q;
  logic             attn_n_q;

  mmsc_flag_if #(.N(2 * mmsc_pkg::LANES)) fi ();

  // pins cross into the core clock: two stages, only the second is read
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync_m_q <= SYNC_RST;
      sync_s_q <= SYNC_RST;
    end else begin
      sync_m_q <= {module_reset_n_i, module_select_n_i, scl_i, sda_i, low_power_request_i, tx_fault_i, rx_los_i};
      sync_s_q <= sync_m_q;
    end
  end

  assign rst_n_s = sync_s_q[NSYNC-1];
  assign sel_n_s = sync_s_q[NSYNC-2];
  assign scl_s   = sync_s_q[NSYNC-3];
  assign sda_s   = sync_s_q[NSYNC-4];
  assign lp_s    = sync_s_q[NSYNC-5];

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  assign start_w  = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_w   = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // reset pin qualifier: short glitches below the minimum pulse are ignored
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rst_cnt_q <= 8'h00;
    end else if (rst_n_s) begin
      rst_cnt_q <= 8'h00;
    end else if (rst_cnt_q != mmsc_pkg::RESET_MIN_CNT) begin
      rst_cnt_q <= rst_cnt_q + 8'h01;
    end
  end

  assign soft_rst_w = ~rst_n_s && (rst_cnt_q == mmsc_pkg::RESET_MIN_CNT);

  // power-on and hot plug both arrive as reset_i, so the block starts in init
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ms_q        <= mmsc_pkg::MS_INIT;
      init_cnt_q  <= 32'h0000_0000;
      ready_evt_q <= 1'b0;
      dnr_q       <= 1'b1;
    end else begin
      ready_evt_q <= 1'b0;
      if (soft_rst_w) begin
        ms_q  <= mmsc_pkg::MS_RESET;
        dnr_q <= 1'b1;
      end else begin
        case (ms_q)
          mmsc_pkg::MS_RESET: begin
            if (rst_n_s) begin
              ms_q       <= mmsc_pkg::MS_INIT;
              init_cnt_q <= 32'h0000_0000;
            end
          end
          mmsc_pkg::MS_INIT: begin
            if (init_cnt_q == 32'(INIT_CYCLES - 1)) begin
              ms_q        <= mmsc_pkg::MS_READY;
              ready_evt_q <= 1'b1;
              dnr_q       <= 1'b0;
            end else begin
              init_cnt_q <= init_cnt_q + 32'h0000_0001;
            end
          end
          mmsc_pkg::MS_READY: begin
            ms_q <= mmsc_pkg::MS_READY;
          end
          default: begin
            ms_q <= mmsc_pkg::MS_INIT;
          end
        endcase
      end
    end
  end

  // the bus is quiet until ready and while deselected
  assign live_w = ~sel_n_s && (ms_q == mmsc_pkg::MS_READY);

  always_comb begin
    rd_byte = 8'h00;
    case (ptr_q)
      mmsc_pkg::ADDR_IDENT:      rd_byte = IDENT_CODE;
      mmsc_pkg::ADDR_STATUS:     rd_byte = 8'(dnr_q) << mmsc_pkg::STATUS_DNR_BIT;
      mmsc_pkg::ADDR_FLAG_LOS:   rd_byte = 8'(fi.flags[mmsc_pkg::LANES-1:0]);
      mmsc_pkg::ADDR_FLAG_FAULT: rd_byte = 8'(fi.flags[2*mmsc_pkg::LANES-1:mmsc_pkg::LANES]);
      mmsc_pkg::ADDR_CTRL_POWER: rd_byte = ctrl_q;
      mmsc_pkg::ADDR_MASK_LOS:   rd_byte = mask_los_q;
      mmsc_pkg::ADDR_MASK_FAULT: rd_byte = mask_fault_q;
      default:                   rd_byte = 8'h00;
    endcase
  end

  assign wr_w = (ser_q == mmsc_pkg::SER_WDATA) && scl_fall && (cnt_q == mmsc_pkg::CNT_BYTE) && !first_q && live_w;
  assign ld_w = live_w && !start_w && !stop_w && scl_fall &&
                (((ser_q == mmsc_pkg::SER_AACK) && rw_q) || (ser_q == mmsc_pkg::SER_RACK));

  // serial slave: sample on the rising clock, change the data line after the falling clock
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ser_q   <= mmsc_pkg::SER_IDLE;
      cnt_q   <= 4'h0;
      shift_q <= 8'h00;
      tx_q    <= 8'h00;
      ptr_q   <= 8'h00;
      rw_q    <= 1'b0;
      first_q <= 1'b0;
      drive_q <= 1'b0;
    end else if (!live_w) begin
      ser_q   <= mmsc_pkg::SER_IDLE;
      drive_q <= 1'b0;
      cnt_q   <= 4'h0;
    end else if (start_w) begin
      ser_q   <= mmsc_pkg::SER_ADDR;
      drive_q <= 1'b0;
      cnt_q   <= 4'h0;
    end else if (stop_w) begin
      ser_q   <= mmsc_pkg::SER_IDLE;
      drive_q <= 1'b0;
    end else begin
      case (ser_q)
        mmsc_pkg::SER_IDLE: begin
          drive_q <= 1'b0;
        end
        mmsc_pkg::SER_ADDR: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s};
            cnt_q   <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == mmsc_pkg::CNT_BYTE) begin
            if (shift_q[7:1] == mmsc_pkg::DEV_ADDR) begin
              drive_q <= 1'b1;
              rw_q    <= shift_q[0];
              ser_q   <= mmsc_pkg::SER_AACK;
            end else begin
              ser_q <= mmsc_pkg::SER_IDLE;
            end
          end
        end
        mmsc_pkg::SER_AACK: begin
          if (scl_fall) begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              tx_q    <= rd_byte;
              drive_q <= ~rd_byte[7];
              ptr_q   <= ptr_q + 8'h01;
              ser_q   <= mmsc_pkg::SER_RDATA;
            end else begin
              drive_q <= 1'b0;
              first_q <= 1'b1;
              ser_q   <= mmsc_pkg::SER_WDATA;
            end
          end
        end
        mmsc_pkg::SER_WDATA: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s};
            cnt_q   <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == mmsc_pkg::CNT_BYTE) begin
            drive_q <= 1'b1;
            ser_q   <= mmsc_pkg::SER_WACK;
            ptr_q   <= first_q ? shift_q : ptr_q + 8'h01;
          end
        end
        mmsc_pkg::SER_WACK: begin
          if (scl_fall) begin
            drive_q <= 1'b0;
            cnt_q   <= 4'h0;
            first_q <= 1'b0;
            ser_q   <= mmsc_pkg::SER_WDATA;
          end
        end
        mmsc_pkg::SER_RDATA: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == mmsc_pkg::CNT_BYTE) begin
              drive_q <= 1'b0;
              ser_q   <= mmsc_pkg::SER_RACK;
            end else begin
              tx_q    <= {tx_q[6:0], 1'b0};
              drive_q <= ~tx_q[6];
            end
          end
        end
        mmsc_pkg::SER_RACK: begin
          if (scl_rise && sda_s) begin
            ser_q <= mmsc_pkg::SER_IDLE; // master ends the read with a nack
          end else if (scl_fall) begin
            cnt_q   <= 4'h0;
            tx_q    <= rd_byte;
            drive_q <= ~rd_byte[7];
            ptr_q   <= ptr_q + 8'h01;
            ser_q   <= mmsc_pkg::SER_RDATA;
          end
        end
        default: begin
          ser_q   <= mmsc_pkg::SER_IDLE;
          drive_q <= 1'b0;
        end
      endcase
    end
  end

  // writable bytes take effect at the data acknowledge, ahead of the stop
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mask_los_q   <= mmsc_pkg::MASK_RST;
      mask_fault_q <= mmsc_pkg::MASK_RST;
      ctrl_q       <= mmsc_pkg::CTRL_RST;
    end else if (soft_rst_w) begin
      mask_los_q   <= mmsc_pkg::MASK_RST;
      mask_fault_q <= mmsc_pkg::MASK_RST;
      ctrl_q       <= mmsc_pkg::CTRL_RST;
    end else if (wr_w) begin
      case (ptr_q)
        mmsc_pkg::ADDR_MASK_LOS:   mask_los_q   <= shift_q;
        mmsc_pkg::ADDR_MASK_FAULT: mask_fault_q <= shift_q;
        mmsc_pkg::ADDR_CTRL_POWER: ctrl_q       <= shift_q;
        default: begin
          ctrl_q <= ctrl_q;
        end
      endcase
    end
  end

  // only the flag bits shipped in the byte are cleared, so a later event is kept; a status read clears ready_pend
  assign fi.cond      = sync_s_q[2*mmsc_pkg::LANES-1:0];
  assign fi.clear     = !ld_w ? '0 :
                        (ptr_q == mmsc_pkg::ADDR_FLAG_LOS)   ? {{mmsc_pkg::LANES{1'b0}}, rd_byte[mmsc_pkg::LANES-1:0]} :
                        (ptr_q == mmsc_pkg::ADDR_FLAG_FAULT) ? {rd_byte[mmsc_pkg::LANES-1:0], {mmsc_pkg::LANES{1'b0}}} :
                        '0;
  assign fi.mask      = {mask_fault_q[mmsc_pkg::LANES-1:0], mask_los_q[mmsc_pkg::LANES-1:0]};
  assign fi.wipe      = soft_rst_w || (ms_q == mmsc_pkg::MS_RESET);
  assign fi.ready_evt = ready_evt_q;
  assign fi.ready_clr = ld_w && (ptr_q == mmsc_pkg::ADDR_STATUS);

  mmsc_flag_bank #(.N(2 * mmsc_pkg::LANES)) u_flags (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .fi      (fi.bank)
  );

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      attn_n_q <= 1'b1;
      lp_q     <= 1'b0;
    end else begin
      attn_n_q <= ~fi.attention;
      lp_q     <= lp_s | ctrl_q[mmsc_pkg::CTRL_OVR_BIT];
    end
  end

  assign sda_o             = 1'b0;
  assign sda_oe_o          = drive_q;
  assign attention_out_n_o = attn_n_q;
  assign presence_out_n_o  = 1'b0;
  assign low_power_o       = lp_q;
  assign data_not_ready_o  = dnr_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence ready_s;
    $rose(ms_q == mmsc_pkg::MS_READY);
  endsequence
  sequence addr_hit_s;
    (ser_q == mmsc_pkg::SER_ADDR) && scl_fall && (cnt_q == mmsc_pkg::CNT_BYTE) &&
    (shift_q[7:1] == mmsc_pkg::DEV_ADDR) && live_w && !start_w && !stop_w;
  endsequence

  reset_qualify_a: assert property (soft_rst_w |=> ms_q == mmsc_pkg::MS_RESET && dnr_q)
    else $error("qualified reset pulse not taken");
  init_bound_a: assert property ((ms_q == mmsc_pkg::MS_INIT && init_cnt_q == 32'(INIT_CYCLES - 1) && !soft_rst_w)
                                 |=> ms_q == mmsc_pkg::MS_READY && ready_evt_q && !dnr_q)
    else $error("init did not end on its last count");
  ready_attn_a: assert property (ready_s |-> ##[1:3] !attention_out_n_o)
    else $error("attention not asserted after data-not-ready cleared");
  lp_entry_a: assert property ($rose(lp_s) |=> low_power_o)
    else $error("low-power pin not obeyed");
  override_on_a: assert property ($rose(ctrl_q[mmsc_pkg::CTRL_OVR_BIT]) |=> low_power_o)
    else $error("power override did not lower power");
  override_off_a: assert property (($fell(ctrl_q[mmsc_pkg::CTRL_OVR_BIT]) && !lp_s) |=> !low_power_o)
    else $error("power override release not obeyed");
  deselect_quiet_a: assert property (sel_n_s |=> ser_q == mmsc_pkg::SER_IDLE && !sda_oe_o)
    else $error("bus driven while deselected");
  not_ready_quiet_a: assert property ((ms_q != mmsc_pkg::MS_READY) |=> !sda_oe_o)
    else $error("bus driven before ready");
  select_ack_a: assert property (addr_hit_s |=> sda_oe_o && ser_q == mmsc_pkg::SER_AACK)
    else $error("address not acknowledged while selected");
  attn_set_a: assert property ((|(fi.flags & fi.mask ^ fi.flags)) |=> !attention_out_n_o)
    else $error("unmasked flag without attention");
  attn_release_a: assert property (((fi.flags & ~fi.mask) == '0 && !fi.ready_pend) |=> attention_out_n_o)
    else $error("attention held with no unmasked source");
  mask_write_a: assert property ((wr_w && ptr_q == mmsc_pkg::ADDR_MASK_LOS && !soft_rst_w)
                                 |=> mask_los_q == $past(shift_q))
    else $error("mask write not applied");

endmodule

// *** testbench/mmsc_host.sv ***
/*
  mmsc_host: host board model, a two-wire serial master driving the clock and data lines.
  assumes a 100 MHz clk_i; the bit time is 16 cycles (160 ns) and the data wire has a pull-up.
*/
`timescale 1ns/100ps
module mmsc_host (
  input  wire logic clk_i,
  input  wire logic sda_oe_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic hl_q  = 1'b0;
  logic scl_q = 1'b1;
  // clock stands high between frames; a released data line reads high
  assign scl_o = scl_q;
  assign sda_o = !(hl_q | sda_oe_i);
  // low phase 2 + 7 cycles, high phase 7 cycles: 160 ns per bit
  task half();
    repeat (7) @(posedge clk_i);
    #1;
  endtask
  // data moves two cycles after the clock falls, so it never looks like a start or stop
  task fall();
    scl_q = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task bitx(input logic b, output logic r);
    hl_q = !b;
    half();
    scl_q = 1'b1;
    half();
    r = sda_o;
    fall();
  endtask
  task start();
    hl_q = 1'b0;
    half();
    scl_q = 1'b1;
    half();
    hl_q = 1'b1;
    half();
    fall();
  endtask
  task stop();
    hl_q = 1'b1;
    half();
    scl_q = 1'b1;
    half();
    hl_q = 1'b0;
    half();
  endtask
  task xbyte(input logic [7:0] d, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(1'b1, a);
    ack = !a;
  endtask
endmodule

// *** testbench/module_mgmt_status_control_test.sv ***
/*
  module_mgmt_status_control_test: self-checking bench for mmsc_top through its pins.
  assumes mmsc_host as the serial master and a shortened initialisation count.
*/
`timescale 1ns/100ps
module module_mgmt_status_control_test;
  localparam logic [7:0] IDENT = 8'h5a;  // arbitrary identifier value
  logic       clk, reset, rst_n, sel_n, lp, scl, sda, oe, att_n, lp_o, dnr, sdo, prs;
  logic [3:0] los, flt;
  int         errors = 0;
  int         total_checks = 0;
  mmsc_host host (.clk_i(clk), .sda_oe_i(oe), .scl_o(scl), .sda_o(sda));
  mmsc_top #(.INIT_CYCLES(50), .IDENT_CODE(IDENT)) DUT (
    .clk_i(clk), .reset_i(reset), .module_reset_n_i(rst_n), .module_select_n_i(sel_n),
    .low_power_request_i(lp), .scl_i(scl), .sda_i(sda), .rx_los_i(los), .tx_fault_i(flt),
    .sda_o(sdo), .sda_oe_o(oe), .attention_out_n_o(att_n), .presence_out_n_o(prs),
    .low_power_o(lp_o), .data_not_ready_o(dnr));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task results();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function logic pick(input int s);
    case (s)
      0: pick = att_n;
      1: pick = lp_o;
      default: pick = dnr;
    endcase
  endfunction
  // bounded wait: the limit is a ceiling, not the expected latency
  task await(input int s, input logic e, input int n);
    for (int i = 0; i < n && pick(s) !== e; i++) cyc(1);
    check({7'h00, pick(s)}, {7'h00, e});
  endtask
  task wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] r;
    logic       a;
    host.start();
    host.xbyte({mmsc_pkg::DEV_ADDR, 1'b0}, r, a);
    host.xbyte(p, r, a);
    host.xbyte(d, r, a);
    host.stop();
  endtask
  task rdc(input logic [7:0] p, input logic [7:0] e, input logic ea);
    logic [7:0] r, v;
    logic       a, b;
    host.start();
    host.xbyte({mmsc_pkg::DEV_ADDR, 1'b0}, r, a);
    host.xbyte(p, r, b);
    host.start();
    host.xbyte({mmsc_pkg::DEV_ADDR, 1'b1}, r, b);
    host.xbyte(8'hff, v, b);
    host.stop();
    check(v, e);
    check({7'h00, a}, {7'h00, ea});
  endtask
  // two-byte read: the host acks the first byte, so the pointer advances inside one transfer
  task rd2(input logic [7:0] p, input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] r, v0, v1;
    logic       a, b;
    host.start();
    host.xbyte({mmsc_pkg::DEV_ADDR, 1'b0}, r, a);
    host.xbyte(p, r, b);
    host.start();
    host.xbyte({mmsc_pkg::DEV_ADDR, 1'b1}, r, b);
    for (int i = 7; i >= 0; i--) host.bitx(1'b1, v0[i]);
    host.bitx(1'b0, b);
    host.xbyte(8'hff, v1, b);
    host.stop();
    check(v0, e0);
    check(v1, e1);
    check({7'h00, a}, 8'h01);
  endtask
  // about three and a half times the expected run length
  initial begin
    #400_000;
    errors++;
    results();
  end
  initial begin
    reset = 1'b1;
    rst_n = 1'b1;
    sel_n = 1'b0;
    lp = 1'b0;
    los = 4'h0;
    flt = 4'h0;
    cyc(20);
    reset = 1'b0;
    await(2, 1'b0, 80);
    await(0, 1'b0, 5);
    rdc(mmsc_pkg::ADDR_IDENT, IDENT, 1'b1);
    check({6'h00, sdo, prs}, 8'h00);
    rdc(mmsc_pkg::ADDR_STATUS, 8'h00, 1'b1);
    await(0, 1'b1, 10);
    $display("test init done");
    los = 4'h4;
    await(0, 1'b0, 10);
    rdc(mmsc_pkg::ADDR_FLAG_LOS, 8'h04, 1'b1);
    await(0, 1'b1, 10);
    rdc(mmsc_pkg::ADDR_FLAG_LOS, 8'h00, 1'b1);
    flt = 4'h8;
    await(0, 1'b0, 10);
    rdc(mmsc_pkg::ADDR_FLAG_FAULT, 8'h08, 1'b1);
    await(0, 1'b1, 10);
    $display("test flags done");
    wr(mmsc_pkg::ADDR_MASK_LOS, 8'h0f);
    rdc(mmsc_pkg::ADDR_MASK_LOS, 8'h0f, 1'b1);
    los = 4'h5;
    cyc(20);
    check({7'h00, att_n}, 8'h01);
    wr(mmsc_pkg::ADDR_MASK_LOS, 8'h00);
    await(0, 1'b0, 10);
    rdc(mmsc_pkg::ADDR_FLAG_LOS, 8'h01, 1'b1);
    await(0, 1'b1, 10);
    $display("test mask done");
    lp = 1'b1;
    await(1, 1'b1, 5);
    lp = 1'b0;
    await(1, 1'b0, 5);
    wr(mmsc_pkg::ADDR_CTRL_POWER, 8'h01);
    await(1, 1'b1, 5);
    rdc(mmsc_pkg::ADDR_CTRL_POWER, 8'h01, 1'b1);
    wr(mmsc_pkg::ADDR_CTRL_POWER, 8'h00);
    await(1, 1'b0, 5);
    $display("test power done");
    sel_n = 1'b1;
    cyc(10);
    rdc(mmsc_pkg::ADDR_IDENT, 8'hff, 1'b0);
    sel_n = 1'b0;
    cyc(10);
    rdc(mmsc_pkg::ADDR_IDENT, IDENT, 1'b1);
    $display("test select done");
    wr(mmsc_pkg::ADDR_MASK_FAULT, 8'h0f);
    rd2(mmsc_pkg::ADDR_MASK_LOS, 8'h00, 8'h0f);
    rst_n = 1'b0;
    cyc(100);
    rst_n = 1'b1;
    cyc(10);
    check({7'h00, dnr}, 8'h00);
    rdc(mmsc_pkg::ADDR_MASK_FAULT, 8'h0f, 1'b1);
    // host holds the pin low well past the minimum pulse
    rst_n = 1'b0;
    cyc(300);
    check({7'h00, dnr}, 8'h01);
    rst_n = 1'b1;
    await(2, 1'b0, 80);
    await(0, 1'b0, 5);
    rdc(mmsc_pkg::ADDR_MASK_FAULT, 8'h00, 1'b1);
    $display("test reset pin done");
    results();
  end
endmodule
